// ==== nas_led_flash.sv ====
// module: free toggle of the green led at a fixed interval while enabled
module nas_led_flash #(
  parameter longint INTERVAL_CYCLES = nas_pkg::LED_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic enable, // flashing wanted
  output logic ledFlash // led level
);

  localparam int CW = $clog2(INTERVAL_CYCLES);

  logic [CW-1:0] count;

  initial begin
    if (INTERVAL_CYCLES < 2) begin
      $error("interval must be at least two cycles");
    end
  end

  // interval counter; restarts whenever flashing is off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (!enable || count == CW'(INTERVAL_CYCLES - 1)) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // led level flips once per interval
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ledFlash <= 1'b0;
    end else if (!enable) begin
      ledFlash <= 1'b0;
    end else if (count == CW'(INTERVAL_CYCLES - 1)) begin
      ledFlash <= !ledFlash;
    end
  end

endmodule

// ==== nas_loader.sv ====
// module: node address loader top with avalon register slave
//
// The address map and register access over Avalon-MM were decided locally.

module nas_loader #(
  parameter bit CAN_VARIANT = 1'b0,
  parameter longint LED_CYCLES = nas_pkg::LED_CYCLES
) (
  input wire logic clk, // 40 mhz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [5:0] addressSelectorSwitch, // switch contacts, on = 1
  input wire logic [3:0] address, // avalon byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  input wire logic [3:0] byteenable, // avalon byte lanes
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait
  output logic [1:0] response, // avalon response code
  output logic [7:0] nodeAddressValue, // resolved node address
  output logic [7:0] stationAlias, // configured station alias
  output logic vendorCanProtocolMode, // vendor can protocol chosen
  output logic lssInactive, // canopen unaddressed state
  output logic statusLedGreen, // green status led
  output logic addressLoaded // configuration is final
);

  // ==========================================================================
  // declarations
  nas_pkg::nas_state_e state;
  logic [5:0] switchSample;
  logic useSoftware;
  logic [7:0] storedAddress;
  logic commitPending;
  logic fromSwitch;
  nas_pkg::nas_cfg_s cfg;
  logic ledFlash;
  logic accept;
  logic ctrlHit;
  logic statusHit;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;

  initial begin
    if (LED_CYCLES < 2) begin
      $error("led interval too short");
    end
  end

  // ==========================================================================
  // avalon slave: one wait cycle, then the access completes
  assign accept = (read || write) && !waitrequest;
  assign ctrlHit = address == nas_pkg::CTRL_OFFSET;
  assign statusHit = address == nas_pkg::STATUS_OFFSET;

  // waitrequest drops for exactly one cycle per access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // register images
  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[nas_pkg::CTRL_USE_SOFTWARE_BIT] = useSoftware;
    ctrlWord[nas_pkg::CTRL_COMMIT_BIT] = commitPending;
    ctrlWord[nas_pkg::CTRL_STORED_LSB +: 8] = storedAddress;
    statusWord = 32'h0000_0000;
    statusWord[nas_pkg::STAT_LOADED_BIT] = addressLoaded;
    statusWord[nas_pkg::STAT_VENDOR_BIT] = vendorCanProtocolMode;
    statusWord[nas_pkg::STAT_LSS_BIT] = lssInactive;
    statusWord[nas_pkg::STAT_FROM_SWITCH_BIT] = fromSwitch;
    statusWord[nas_pkg::STAT_ADDR_LSB +: 8] = nodeAddressValue;
    statusWord[nas_pkg::STAT_ALIAS_LSB +: 8] = stationAlias;
    statusWord[nas_pkg::STAT_SWITCH_LSB +: 6] = switchSample;
  end

  // read data and response are prepared during the wait cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
      response <= nas_pkg::RESP_OKAY;
    end else if ((read || write) && waitrequest) begin
      if (read && ctrlHit) begin
        readdata <= ctrlWord;
      end else if (read && statusHit) begin
        readdata <= statusWord;
      end else begin
        readdata <= 32'h0000_0000;
      end
      // status is read only, so a write to it is refused as well
      if (ctrlHit || (statusHit && read)) begin
        response <= nas_pkg::RESP_OKAY;
      end else begin
        response <= nas_pkg::RESP_DECODEERROR;
      end
    end
  end

  // control register; setup changes after loading have no effect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      useSoftware <= 1'b0;
      storedAddress <= nas_pkg::CTRL_STORED_RESET;
    end else if (accept && write && ctrlHit) begin
      if (byteenable[0]) begin
        useSoftware <= writedata[nas_pkg::CTRL_USE_SOFTWARE_BIT];
      end
      if (byteenable[1]) begin
        storedAddress <= writedata[nas_pkg::CTRL_STORED_LSB +: 8];
      end
    end
  end

  // commit request; a write of one sets it until loading is done, loading clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      commitPending <= 1'b0;
    end else if (accept && write && ctrlHit && byteenable[0]
                 && writedata[nas_pkg::CTRL_COMMIT_BIT] && state != nas_pkg::ST_RUN) begin
      commitPending <= 1'b1;
    end else if (state == nas_pkg::ST_WAIT) begin
      commitPending <= 1'b0;
    end
  end

  // ==========================================================================
  // load sequence: sample, wait for setup commit, run
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= nas_pkg::ST_SAMPLE;
    end else begin
      case (state)
        nas_pkg::ST_SAMPLE: state <= nas_pkg::ST_WAIT;
        nas_pkg::ST_WAIT: begin
          if (commitPending) begin
            state <= nas_pkg::ST_RUN;
          end
        end
        nas_pkg::ST_RUN: state <= nas_pkg::ST_RUN;
        default: state <= nas_pkg::ST_SAMPLE;
      endcase
    end
  end

  // strap capture on the first edge after reset release, never again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      switchSample <= 6'h00;
    end else if (state == nas_pkg::ST_SAMPLE) begin
      switchSample <= addressSelectorSwitch;
    end
  end

  nas_switch_decode #(
    .CAN_VARIANT(CAN_VARIANT)
  ) u_decode (
    .switchSample(switchSample),
    .useSoftware(useSoftware),
    .storedAddress(storedAddress),
    .cfg(cfg)
  );

  // configuration latched once on commit, then frozen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nodeAddressValue <= 8'h00;
      stationAlias <= 8'h00;
      vendorCanProtocolMode <= 1'b0;
      lssInactive <= 1'b0;
      fromSwitch <= 1'b0;
      addressLoaded <= 1'b0;
    end else if (state == nas_pkg::ST_WAIT && commitPending) begin
      nodeAddressValue <= cfg.nodeAddress;
      stationAlias <= cfg.stationAlias;
      vendorCanProtocolMode <= cfg.vendorMode;
      lssInactive <= cfg.lssInactive;
      fromSwitch <= cfg.fromSwitch;
      addressLoaded <= 1'b1;
    end
  end

  // ==========================================================================
  // status led: flashing while unaddressed, steady once addressed
  nas_led_flash #(
    .INTERVAL_CYCLES(LED_CYCLES)
  ) u_led (
    .clk(clk),
    .rstn(rstn),
    .enable(lssInactive),
    .ledFlash(ledFlash)
  );

  // registered so the pin never sees decode glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      statusLedGreen <= 1'b0;
    end else if (lssInactive) begin
      statusLedGreen <= ledFlash;
    end else begin
      statusLedGreen <= addressLoaded;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // cycles since the led last changed while flashing
  logic [31:0] ledHold;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ledHold <= 32'h0000_0000;
    end else if (!lssInactive || statusLedGreen != $past(statusLedGreen)) begin
      ledHold <= 32'h0000_0000;
    end else begin
      ledHold <= ledHold + 32'h0000_0001;
    end
  end

  property p_aliasCopy;
    addressLoaded && !CAN_VARIANT && nodeAddressValue != 8'hff |-> stationAlias == nodeAddressValue;
  endproperty
  a_aliasCopy: assert property (p_aliasCopy) else $error("alias differs from address");

  property p_softSource;
    $rose(addressLoaded) && !fromSwitch |-> nodeAddressValue == $past(storedAddress)
      && nodeAddressValue != 8'h00;
  endproperty
  a_softSource: assert property (p_softSource) else $error("stored address not used");

  property p_switchSource;
    $rose(addressLoaded) && (!$past(useSoftware) || $past(storedAddress) == 8'h00) |-> fromSwitch;
  endproperty
  a_switchSource: assert property (p_switchSource) else $error("switch source not taken");

  property p_ecatMap;
    addressLoaded && !CAN_VARIANT && fromSwitch
      |-> nodeAddressValue == {switchSample[5], 2'b00, switchSample[4:0]};
  endproperty
  a_ecatMap: assert property (p_ecatMap) else $error("ethercat switch mapping wrong");

  property p_alias255;
    addressLoaded && nodeAddressValue == 8'hff |-> stationAlias == 8'h00;
  endproperty
  a_alias255: assert property (p_alias255) else $error("alias not zero at 255");

  property p_sampleOnce;
    state != nas_pkg::ST_SAMPLE |=> $stable(switchSample);
  endproperty
  a_sampleOnce: assert property (p_sampleOnce) else $error("switch resampled");

  property p_canMap;
    addressLoaded && CAN_VARIANT && fromSwitch && switchSample[4:0] != 5'h00
      |-> nodeAddressValue == {3'b000, switchSample[4:0]};
  endproperty
  a_canMap: assert property (p_canMap) else $error("can switch mapping wrong");

  property p_canMax;
    addressLoaded && CAN_VARIANT && fromSwitch |-> nodeAddressValue <= 8'h1f
      || nodeAddressValue == 8'hff;
  endproperty
  a_canMax: assert property (p_canMax) else $error("can switch address above 31");

  property p_canZero;
    addressLoaded && CAN_VARIANT && fromSwitch && switchSample[4:0] == 5'h00
      |-> nodeAddressValue == 8'hff;
  endproperty
  a_canZero: assert property (p_canZero) else $error("all-zero switch not 255");

  property p_lssFlash;
    lssInactive |-> ledHold <= 32'(LED_CYCLES + 1);
  endproperty
  a_lssFlash: assert property (p_lssFlash) else $error("led interval too long");

  property p_lssEnter;
    $rose(addressLoaded) && CAN_VARIANT && !vendorCanProtocolMode && nodeAddressValue == 8'hff
      |-> lssInactive;
  endproperty
  a_lssEnter: assert property (p_lssEnter) else $error("lss inactive not entered");

  property p_protocol;
    addressLoaded && CAN_VARIANT |-> vendorCanProtocolMode == switchSample[5];
  endproperty
  a_protocol: assert property (p_protocol) else $error("protocol bit wrong");

  property p_frozen;
    addressLoaded |=> addressLoaded && $stable(nodeAddressValue)
      && $stable(vendorCanProtocolMode) && $stable(stationAlias);
  endproperty
  a_frozen: assert property (p_frozen) else $error("configuration changed");

  c_fromSwitch: cover property ($rose(addressLoaded) && fromSwitch);
  c_fromSoftware: cover property ($rose(addressLoaded) && !fromSwitch);
  c_lss: cover property (lssInactive ##1 $changed(statusLedGreen));
  c_decodeError: cover property (!waitrequest && response == nas_pkg::RESP_DECODEERROR);

endmodule

// ==== nas_pkg.sv ====
// package: constants, states and carrier types of the node address loader
package nas_pkg;

  // ==========================================================================
  // register map (byte addresses on the avalon slave)
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // control register fields
  localparam int CTRL_USE_SOFTWARE_BIT = 0;
  localparam int CTRL_COMMIT_BIT = 1;
  localparam int CTRL_STORED_LSB = 8;
  localparam logic [7:0] CTRL_STORED_RESET = 8'h00;

  // status register fields
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_VENDOR_BIT = 1;
  localparam int STAT_LSS_BIT = 2;
  localparam int STAT_FROM_SWITCH_BIT = 3;
  localparam int STAT_ADDR_LSB = 8;
  localparam int STAT_ALIAS_LSB = 16;
  localparam int STAT_SWITCH_LSB = 24;

  // avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODEERROR = 2'h3;

  // ==========================================================================
  // address values
  localparam int SWITCH_WIDTH = 6;
  localparam logic [7:0] ADDR_UNSET = 8'hff;
  localparam logic [7:0] ADDR_INVALID = 8'h00;
  localparam logic [7:0] CAN_ADDR_MAX = 8'h1f;

  // ==========================================================================
  // timing: green led interval while the can stack sits unaddressed
  localparam longint CLK_HZ = 40_000_000;
  localparam longint LED_INTERVAL_MS = 1000;
  localparam longint LED_CYCLES = (LED_INTERVAL_MS * CLK_HZ) / 1000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b11
  } nas_state_e;

  typedef struct packed {
    logic [7:0] nodeAddress;
    logic [7:0] stationAlias;
    logic vendorMode;
    logic lssInactive;
    logic fromSwitch;
  } nas_cfg_s;

endpackage

// ==== nas_switch_decode.sv ====
// module: turns the sampled switch and stored setup into a node configuration
module nas_switch_decode #(
  parameter bit CAN_VARIANT = 1'b0
) (
  input wire logic [5:0] switchSample, // frozen switch reading
  input wire logic useSoftware, // software source chosen
  input wire logic [7:0] storedAddress, // stored node address
  output nas_pkg::nas_cfg_s cfg // resolved configuration
);

  logic [7:0] switchAddress;
  logic takeSwitch;
  logic [7:0] resolved;

  // switch to address mapping per variant
  always_comb begin
    if (CAN_VARIANT) begin
      if (switchSample[4:0] == 5'h0_0) begin
        switchAddress = nas_pkg::ADDR_UNSET;
      end else begin
        switchAddress = {3'h0, switchSample[4:0]};
      end
    end else begin
      switchAddress = {switchSample[5], 2'h0, switchSample[4:0]};
    end
  end

  // a zero stored address counts as an invalid setup
  assign takeSwitch = !useSoftware || (storedAddress == nas_pkg::ADDR_INVALID);
  assign resolved = takeSwitch ? switchAddress : storedAddress;

  // pack the outcome
  always_comb begin
    cfg.nodeAddress = resolved;
    cfg.fromSwitch = takeSwitch;
    cfg.vendorMode = CAN_VARIANT && switchSample[5];
    cfg.lssInactive = CAN_VARIANT && !switchSample[5] && (resolved == nas_pkg::ADDR_UNSET);
    if (!CAN_VARIANT && resolved != nas_pkg::ADDR_UNSET) begin
      cfg.stationAlias = resolved;
    end else begin
      cfg.stationAlias = 8'h00;
    end
  end

endmodule

// ==== nas_switch_model.sv ====
// switch contact model: six sliding positions seen by the loader
module nas_switch_model (
  input wire logic [5:0] setting, // positions 1..6 chosen by the bench
  output logic [5:0] contacts // contact levels, on = 1
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // contacts
  // contacts are hard-wired switch levels; no bounce is modelled, so any
  // later movement is a clean step the loader must still ignore
  assign contacts = setting;
endmodule

// ==== test_nas_loader.sv ====
// testbench: both loader variants driven through the avalon slave
module test_nas_loader;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // clock, reset and shared bus
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] swSetting = 6'h00;
  logic [5:0] swContacts;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] eRdata, cRdata;
  logic eWait, cWait;
  logic [1:0] eResp, cResp;
  logic [7:0] eNode, eAlias, cNode, cAlias;
  logic eVendor, eLss, eLed, eLoaded, cVendor, cLss, cLed, cLoaded;
  int mismatches = 0;
  int numChecks = 0;
  // 40 mhz
  always #12.5 clk = ~clk;
  nas_switch_model nas_switch_model_i (.setting(swSetting), .contacts(swContacts));
  // ==========================================================================
  // one instance per variant; both share the bus so each access hits both
  nas_loader #(.CAN_VARIANT(1'b0), .LED_CYCLES(8)) nas_loader_i (
    .clk(clk), .rstn(rstn), .addressSelectorSwitch(swContacts), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(eRdata), .waitrequest(eWait), .response(eResp), .nodeAddressValue(eNode),
    .stationAlias(eAlias), .vendorCanProtocolMode(eVendor), .lssInactive(eLss),
    .statusLedGreen(eLed), .addressLoaded(eLoaded));
  nas_loader #(.CAN_VARIANT(1'b1), .LED_CYCLES(8)) nas_loader_can_i (
    .clk(clk), .rstn(rstn), .addressSelectorSwitch(swContacts), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(cRdata), .waitrequest(cWait), .response(cResp), .nodeAddressValue(cNode),
    .stationAlias(cAlias), .vendorCanProtocolMode(cVendor), .lssInactive(cLss),
    .statusLedGreen(cLed), .addressLoaded(cLoaded));
  // ==========================================================================
  // reporting
  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================================================
  // avalon access: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    int n;
    @(posedge clk);
    address <= adr;
    writedata <= wd;
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (eWait === 1'b0) break;
    end
    if (n == 20) begin
      mismatches++;
      final_report();
    end
    rd = eRdata;
    rs = eResp;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // ==========================================================================
  // one power-up: reset, configure and commit, then compare both variants
  task automatic run_case(input logic [5:0] sw, input logic useSw, input logic [7:0] st);
    logic [7:0] ea, ca;
    logic valid, ven, lss, prev;
    logic [31:0] rd;
    logic [1:0] rs;
    int tog;
    swSetting <= sw;
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b1, 4'h0, {16'h0000, st, 6'h00, 1'b1, useSw}, 4'h3, rd, rs);
    check(rs, 2'h0);
    repeat (3) @(posedge clk);
    valid = useSw && st != 8'h00;
    ea = valid ? st : {sw[5], 2'b00, sw[4:0]};
    ca = valid ? st : (sw[4:0] == 5'h00 ? 8'hff : {3'b000, sw[4:0]});
    ven = sw[5];
    lss = !ven && ca == 8'hff;
    check(eNode, ea);
    check(eAlias, ea == 8'hff ? 8'h00 : ea);
    check({eVendor, eLss, eLoaded}, 3'b001);
    check(cNode, ca);
    check(cAlias, 8'h00);
    check(cVendor, ven);
    check(cLss, lss);
    check(cLoaded, 1'b1);
    // count led changes over 32 cycles; an interval of 8 gives exactly four
    tog = 0;
    prev = cLed;
    repeat (32) begin
      @(posedge clk);
      if (cLed !== prev) tog++;
      prev = cLed;
    end
    check(tog, lss ? 4 : 0);
    check(eLed, 1'b1);
    // move the switch after load; nothing may follow it
    swSetting <= ~sw;
    repeat (4) @(posedge clk);
    check({eNode, cNode, cVendor}, {ea, ca, ven});
    bus(1'b0, 4'h4, 32'h0000_0000, 4'hf, rd, rs);
    check(rd[15:0], {ea, 4'h0, !valid, 3'b001});
    check(rd[29:24], sw);
    // the can instance answers on the same bus cycle; its image stands as well
    check({cRdata[29:24], cRdata[15:0]}, {sw, ca, 4'h0, !valid, lss, ven, 1'b1});
    check({eResp, cResp}, 4'h0);
    // a new setup and commit after load must leave the outputs alone
    bus(1'b1, 4'h0, {16'h0000, ~st, 6'h00, 1'b1, ~useSw}, 4'h3, rd, rs);
    check(rs, 2'h0);
    repeat (2) @(posedge clk);
    check({eNode, eAlias, cNode, cVendor, cLss, cLoaded},
          {ea, (ea == 8'hff ? 8'h00 : ea), ca, ven, lss, 1'b1});
    // setup is stored, but the commit bit stays clear once loaded
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hf, rd, rs);
    check(rd[15:0], {~st, 6'h00, 1'b0, ~useSw});
    $display("test done: switch %h source %0d stored %h", sw, useSw, st);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic [5:0] swTab [5] = '{6'b101101, 6'b100000, 6'b011111, 6'b000011, 6'b010110};
    logic useTab [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [7:0] stTab [5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h42};
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // unmapped read and status write are refused
    bus(1'b0, 4'h8, 32'h0000_0000, 4'hf, rd, rs);
    check({rs, rd}, {2'h3, 32'h0000_0000});
    bus(1'b1, 4'h4, 32'hffff_ffff, 4'hf, rd, rs);
    check(rs, 2'h3);
    check({eLoaded, eNode}, 9'h000);
    $display("test done: refused accesses");
    for (int i = 0; i < 5; i++) begin
      run_case(swTab[i], useTab[i], stTab[i]);
    end
    final_report();
  end
endmodule
